// ---- rtl/amp_scan_pkg.sv ----
// Shared constants and types for the amplifier scan sequencer
package amp_scan_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_NS = 1000000;
  localparam int TICK_CYCLES_DFLT = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GROUP_DWELL_S = 5;
  localparam int GROUP1_DWELL_S = 8;
  localparam int MODE_TIMEOUT_MIN = 30;
  localparam int GROUP_DWELL_MS_DFLT = GROUP_DWELL_S * 1000;
  localparam int GROUP1_DWELL_MS_DFLT = GROUP1_DWELL_S * 1000;
  localparam int MODE_TIMEOUT_MS_DFLT = MODE_TIMEOUT_MIN * 60 * 1000;
  localparam int FAST_DWELL_MS = 1;
  localparam int HOLDOFF_NS = 100;
  localparam int HOLDOFF_CYCLES = (HOLDOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Equipment layout
  // ---------------------------------------------------------------
  localparam int NUM_BAYS_DFLT = 3;
  localparam int BANKS = 4;
  localparam int SHELVES_PER_BAY = 13;
  localparam int SHELF_TOTAL = BANKS * SHELVES_PER_BAY;
  localparam int SHELF_IDX_W = 6;
  localparam int DEV_W = 8;
  localparam logic [1:0] SPARE_BAY = 2'h3;
  localparam logic [1:0] FIRST_BAY = 2'h0;
  localparam logic [3:0] FIRST_SHELF = 4'h0;
  localparam logic [3:0] LAST_SG_SHELF = 4'hB;
  localparam logic [3:0] SGS_SHELF = 4'hC;
  localparam logic [2:0] FIRST_GRP = 3'h0;
  localparam logic [2:0] LAST_GRP = 3'h4;

  typedef struct packed {
    logic [1:0] bay;
    logic [3:0] shelf;
    logic [2:0] grp;
  } pos_t;

  typedef enum logic [2:0] {
    MODE_SCAN = 3'b001,
    MODE_HOLD = 3'b010,
    MODE_SELECT = 3'b100
  } mode_t;

  typedef enum logic [1:0] {
    PH_MOVE = 2'b01,
    PH_DWELL = 2'b10
  } phase_t;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_SELECT = 8'h04;
  localparam logic [7:0] REG_OPTION = 8'h08;
  localparam logic [7:0] REG_LIMIT = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_EOR_LO = 8'h14;
  localparam logic [7:0] REG_EOR_HI = 8'h18;
  localparam int CMD_HOLD = 0;
  localparam int CMD_SELECT = 1;
  localparam int CMD_SCAN = 2;
  localparam int CMD_STEP = 3;
  localparam int CMD_EOR_RESET = 4;
  localparam int OPT_SPARE_BANK = 0;
  localparam int OPT_HAND_KEY = 1;
  localparam int LIM_LOWER_LSB = 0;
  localparam int LIM_UPPER_LSB = 8;
  localparam int STAT_MODE_LSB = 9;
  localparam int STAT_CONN = 12;
  localparam int STAT_HOLDOFF = 13;
  localparam int STAT_OFFICE = 14;
  localparam logic [1:0] OPTION_RST = 2'h0;
  localparam logic [15:0] LIMIT_RST = 16'h10F0;

endpackage

// ---- rtl/amp_scan_sequencer.sv ----
// Amplifier scan sequencer with mode control, dwell timing and alarms
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module amp_scan_sequencer #(
  parameter int NUM_BAYS = amp_scan_pkg::NUM_BAYS_DFLT,
  parameter int TICK_CYCLES = amp_scan_pkg::TICK_CYCLES_DFLT,
  parameter int DWELL_MS = amp_scan_pkg::GROUP_DWELL_MS_DFLT,
  parameter int DWELL1_MS = amp_scan_pkg::GROUP1_DWELL_MS_DFLT,
  parameter int TIMEOUT_MS = amp_scan_pkg::MODE_TIMEOUT_MS_DFLT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Wiring options, one bit per shelf
  input wire logic [amp_scan_pkg::SHELF_TOTAL-1:0] fastScanOption,
  input wire logic [amp_scan_pkg::SHELF_TOTAL-1:0] groupBypassOption,
  input wire logic [amp_scan_pkg::SHELF_TOTAL-1:0] supergroupBypassOption,
  // Measuring set and detectors
  input wire logic groupEorDetect,
  input wire logic supergroupEorDetect,
  input wire logic signed [amp_scan_pkg::DEV_W-1:0] gainDeviation,
  // Connection and alarm outputs
  output amp_scan_pkg::pos_t connectedPos,
  output logic amplifierConnectedLamp,
  output logic groupMeasureOutput,
  output logic [amp_scan_pkg::BANKS-1:0] bayConcentratorSel,
  output logic eorHoldOff,
  output logic [amp_scan_pkg::SHELF_TOTAL-1:0] shelfEorLamp,
  output logic [amp_scan_pkg::BANKS-1:0] bayAlarm,
  output logic officeAlarm
);
  import amp_scan_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int DW = $clog2(DWELL1_MS + DWELL_MS + 1);
  localparam int OW = $clog2(TIMEOUT_MS + 1);
  localparam int HW = $clog2(HOLDOFF_CYCLES + 1);
  localparam logic [1:0] LAST_BAY = 2'(NUM_BAYS - 1);

  // ---------------------------------------------------------------
  // Position helpers
  // ---------------------------------------------------------------
  function automatic logic [SHELF_IDX_W-1:0] shelfIndex(input pos_t p);
    shelfIndex = SHELF_IDX_W'(p.bay) * SHELF_IDX_W'(SHELVES_PER_BAY)
      + SHELF_IDX_W'(p.shelf);
  endfunction

  function automatic logic isSpare(input pos_t p);
    isSpare = (p.bay == SPARE_BAY);
  endfunction

  // Spare bank holds supergroups only, so it has one position per shelf
  function automatic pos_t nextPos(input pos_t p, input logic gb,
    input logic spareEn, input logic inBay);
    pos_t n;
    logic [2:0] lastGrp;
    logic [3:0] lastShelf;
    n = p;
    lastGrp = (isSpare(p) || gb) ? FIRST_GRP : LAST_GRP;
    lastShelf = isSpare(p) ? LAST_SG_SHELF : SGS_SHELF;
    if (p.grp < lastGrp)
    begin
      n.grp = p.grp + 3'h1;
    end
    else
    begin
      n.grp = FIRST_GRP;
      if (p.shelf < lastShelf)
      begin
        n.shelf = p.shelf + 4'h1;
      end
      else
      begin
        n.shelf = FIRST_SHELF;
        if (inBay)
        begin
          n.bay = p.bay;
        end
        else if (isSpare(p))
        begin
          n.bay = FIRST_BAY;
        end
        else if (p.bay < LAST_BAY)
        begin
          n.bay = p.bay + 2'h1;
        end
        else
        begin
          n.bay = spareEn ? SPARE_BAY : FIRST_BAY;
        end
      end
    end
    nextPos = n;
  endfunction

  function automatic pos_t clampPos(input pos_t p, input logic spareEn);
    pos_t c;
    c = p;
    if (isSpare(p) && !spareEn)
    begin
      c.bay = FIRST_BAY;
    end
    else if (!isSpare(p) && p.bay > LAST_BAY)
    begin
      c.bay = LAST_BAY;
    end
    if (isSpare(c))
    begin
      c.grp = FIRST_GRP;
      c.shelf = (p.shelf > LAST_SG_SHELF) ? LAST_SG_SHELF : p.shelf;
    end
    else
    begin
      c.grp = (p.grp > LAST_GRP) ? LAST_GRP : p.grp;
      c.shelf = (p.shelf > SGS_SHELF) ? SGS_SHELF : p.shelf;
    end
    clampPos = c;
  endfunction

  // ---------------------------------------------------------------
  // APB register file
  // ---------------------------------------------------------------
  pos_t selPos_r, selPos_nxt;
  logic [1:0] option_r, option_nxt;
  logic [15:0] limit_r, limit_nxt;
  logic wrEn;
  logic keyHold, keySelect, keyScan, keyStep, keyEorReset, anyKey;
  mode_t mode_r, mode_nxt;
  phase_t phase_r, phase_nxt;
  pos_t pos_r, pos_nxt;
  logic [SHELF_TOTAL-1:0] eorLamp_r, eorLamp_nxt;
  logic [BANKS-1:0] bayAlarm_r, bayAlarm_nxt;
  logic office_r, office_nxt;

  assign wrEn = psel && penable && pwrite;
  assign keyHold = wrEn && (paddr == REG_CMD) && pwdata[CMD_HOLD];
  assign keySelect = wrEn && (paddr == REG_CMD) && pwdata[CMD_SELECT];
  assign keyScan = wrEn && (paddr == REG_CMD) && pwdata[CMD_SCAN];
  assign keyStep = wrEn && (paddr == REG_CMD) && pwdata[CMD_STEP];
  assign keyEorReset = wrEn && (paddr == REG_CMD) && pwdata[CMD_EOR_RESET];
  assign anyKey = keyHold || keySelect || keyScan;
  assign pready = 1'b1;

  always_comb
  begin
    selPos_nxt = selPos_r;
    option_nxt = option_r;
    limit_nxt = limit_r;
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    if (paddr == REG_CMD)
    begin
      prdata = 32'h0000_0000;
    end
    else if (paddr == REG_SELECT)
    begin
      prdata = 32'(selPos_r);
      if (wrEn)
        selPos_nxt = pos_t'(pwdata[$bits(pos_t)-1:0]);
    end
    else if (paddr == REG_OPTION)
    begin
      prdata = 32'(option_r);
      if (wrEn)
        option_nxt = pwdata[1:0];
    end
    else if (paddr == REG_LIMIT)
    begin
      prdata = 32'(limit_r);
      if (wrEn)
        limit_nxt = pwdata[15:0];
    end
    else if (paddr == REG_STATUS)
    begin
      prdata[$bits(pos_t)-1:0] = pos_r;
      prdata[STAT_MODE_LSB +: 3] = mode_r;
      prdata[STAT_CONN] = (phase_r == PH_DWELL);
      prdata[STAT_HOLDOFF] = (phase_r == PH_MOVE);
      prdata[STAT_OFFICE] = office_r;
    end
    else if (paddr == REG_EOR_LO)
    begin
      prdata = eorLamp_r[31:0];
    end
    else if (paddr == REG_EOR_HI)
    begin
      prdata = 32'(eorLamp_r[SHELF_TOTAL-1:32]);
    end
    else
    begin
      pslverr = psel && penable;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      selPos_r <= '0;
      option_r <= OPTION_RST;
      limit_r <= LIMIT_RST;
    end
    else
    begin
      selPos_r <= selPos_nxt;
      option_r <= option_nxt;
      limit_r <= limit_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Millisecond tick divider
  // ---------------------------------------------------------------
  logic [TW-1:0] tickCnt_r, tickCnt_nxt;
  logic tick;

  assign tick = (tickCnt_r == TW'(TICK_CYCLES - 1));

  always_comb
  begin
    tickCnt_nxt = tick ? '0 : tickCnt_r + TW'(1);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      tickCnt_r <= '0;
    else
      tickCnt_r <= tickCnt_nxt;
  end

  // ---------------------------------------------------------------
  // Mode and scan sequencing
  // ---------------------------------------------------------------
  logic [DW-1:0] dwellMs_r, dwellMs_nxt, dwellLimit;
  logic [OW-1:0] timeoutMs_r, timeoutMs_nxt;
  logic [HW-1:0] moveCnt_r, moveCnt_nxt;
  logic [SHELF_IDX_W-1:0] idx;
  logic optFast, optGrpByp, optSgByp, grpInh, sgInh, allInh, connected;
  pos_t selClamped, stepPos;

  assign idx = shelfIndex(pos_r);
  assign optFast = fastScanOption[idx];
  assign optGrpByp = groupBypassOption[idx];
  assign optSgByp = supergroupBypassOption[idx];
  // Supergroup-bypassed shelves are fast-scanned so no walk ever needs a skip search
  assign allInh = optFast || optSgByp;
  assign grpInh = allInh || optGrpByp || isSpare(pos_r);
  assign sgInh = allInh || (pos_r.shelf == SGS_SHELF);
  assign connected = (phase_r == PH_DWELL);
  assign selClamped = clampPos(selPos_r, option_r[OPT_SPARE_BANK]);
  assign stepPos = nextPos(pos_r, optGrpByp, option_r[OPT_SPARE_BANK],
    mode_r == MODE_HOLD);

  always_comb
  begin
    if (allInh)
      dwellLimit = DW'(FAST_DWELL_MS);
    else if (pos_r.grp == FIRST_GRP && !isSpare(pos_r))
      dwellLimit = DW'(DWELL1_MS);
    else
      dwellLimit = DW'(DWELL_MS);
  end

  always_comb
  begin
    mode_nxt = mode_r;
    phase_nxt = phase_r;
    pos_nxt = pos_r;
    dwellMs_nxt = dwellMs_r;
    timeoutMs_nxt = timeoutMs_r;
    moveCnt_nxt = moveCnt_r;
    if (phase_r == PH_MOVE)
    begin
      if (moveCnt_r == HW'(HOLDOFF_CYCLES - 1))
      begin
        phase_nxt = PH_DWELL;
        dwellMs_nxt = '0;
      end
      else
        moveCnt_nxt = moveCnt_r + HW'(1);
    end
    if (keyScan)
    begin
      mode_nxt = MODE_SCAN;
      dwellMs_nxt = '0;
    end
    else if (keySelect)
    begin
      mode_nxt = MODE_SELECT;
      pos_nxt = selClamped;
      phase_nxt = PH_MOVE;
      moveCnt_nxt = '0;
      timeoutMs_nxt = '0;
    end
    else if (keyHold)
    begin
      mode_nxt = MODE_HOLD;
      timeoutMs_nxt = '0;
    end
    else
    begin
      case (mode_r)
        MODE_SCAN:
        begin
          if (connected && tick)
          begin
            if (dwellMs_r >= dwellLimit - DW'(1))
            begin
              pos_nxt = stepPos;
              phase_nxt = PH_MOVE;
              moveCnt_nxt = '0;
            end
            else
              dwellMs_nxt = dwellMs_r + DW'(1);
          end
        end
        MODE_HOLD, MODE_SELECT:
        begin
          if (keyStep && option_r[OPT_HAND_KEY] && mode_r == MODE_HOLD)
          begin
            pos_nxt = stepPos;
            phase_nxt = PH_MOVE;
            moveCnt_nxt = '0;
          end
          if (tick)
          begin
            if (timeoutMs_r == OW'(TIMEOUT_MS - 1))
            begin
              mode_nxt = MODE_SCAN;
              dwellMs_nxt = '0;
            end
            else
              timeoutMs_nxt = timeoutMs_r + OW'(1);
          end
        end
        default:
          mode_nxt = MODE_SCAN;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_r <= MODE_SCAN;
      phase_r <= PH_MOVE;
      pos_r <= '0;
      dwellMs_r <= '0;
      timeoutMs_r <= '0;
      moveCnt_r <= '0;
    end
    else
    begin
      mode_r <= mode_nxt;
      phase_r <= phase_nxt;
      pos_r <= pos_nxt;
      dwellMs_r <= dwellMs_nxt;
      timeoutMs_r <= timeoutMs_nxt;
      moveCnt_r <= moveCnt_nxt;
    end
  end

  assign connectedPos = pos_r;
  assign amplifierConnectedLamp = connected;
  assign eorHoldOff = (phase_r == PH_MOVE);
  assign groupMeasureOutput = connected && !isSpare(pos_r)
    && (pos_r.shelf != SGS_SHELF || !optGrpByp);

  genvar b;
  generate
    for (b = 0; b < BANKS; b++)
    begin : g_conc
      assign bayConcentratorSel[b] = connected && (pos_r.bay == 2'(b));
    end
  endgenerate

  // ---------------------------------------------------------------
  // End-of-range latches and deviation window
  // ---------------------------------------------------------------
  logic devHigh, devLow;

  assign devHigh = gainDeviation > $signed(limit_r[LIM_UPPER_LSB +: DEV_W]);
  assign devLow = gainDeviation < $signed(limit_r[LIM_LOWER_LSB +: DEV_W]);

  always_comb
  begin
    eorLamp_nxt = eorLamp_r;
    bayAlarm_nxt = '0;
    if (keyEorReset)
      eorLamp_nxt = '0;
    // Detector inputs are ignored in transit while held off
    if (connected && ((groupEorDetect && !grpInh)
      || (supergroupEorDetect && !sgInh)))
      eorLamp_nxt[idx] = 1'b1;
    if (connected && !(grpInh && sgInh) && (devHigh || devLow))
      bayAlarm_nxt[pos_r.bay] = 1'b1;
    office_nxt = |bayAlarm_nxt;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      eorLamp_r <= '0;
      bayAlarm_r <= '0;
      office_r <= 1'b0;
    end
    else
    begin
      eorLamp_r <= eorLamp_nxt;
      bayAlarm_r <= bayAlarm_nxt;
      office_r <= office_nxt;
    end
  end

  assign shelfEorLamp = eorLamp_r;
  assign bayAlarm = bayAlarm_r;
  assign officeAlarm = office_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence sMoveStart;
    $changed(pos_r);
  endsequence

  sequence sHoldQuiet;
    mode_r == MODE_HOLD && !anyKey && !keyStep;
  endsequence

  AST_EOR_SET: assert property (
    connected && groupEorDetect && !grpInh |=> eorLamp_r[$past(idx)])
    else $error("group end-of-range did not light shelf lamp");
  AST_LAMP_LATCH: assert property (
    |(~eorLamp_r & $past(eorLamp_r)) |-> $past(keyEorReset))
    else $error("shelf lamp dropped without reset");
  AST_WINDOW: assert property (
    connected && !(grpInh && sgInh) && devHigh |=> officeAlarm
      && bayAlarm_r[$past(pos_r.bay)])
    else $error("deviation over limit gave no alarm");
  AST_HOLD_STILL: assert property (
    sHoldQuiet |=> $stable(pos_r))
    else $error("position moved in hold");
  AST_SELECT: assert property (
    keySelect && !keyScan |=> pos_r == $past(selClamped)
      && mode_r == MODE_SELECT)
    else $error("select key did not connect switch position");
  AST_SCAN_KEY: assert property (
    keyScan |=> mode_r == MODE_SCAN && $stable(pos_r))
    else $error("scan key did not resume from held position");
  AST_TIMEOUT: assert property (
    tick && timeoutMs_r == OW'(TIMEOUT_MS - 1) && mode_r != MODE_SCAN
      && !anyKey |=> mode_r == MODE_SCAN)
    else $error("mode timer did not return to scan");
  AST_HOLDOFF: assert property (
    sMoveStart |-> eorHoldOff [*8])
    else $error("hold-off missing during transition");
  AST_LAMP_CONN: assert property (
    amplifierConnectedLamp |-> !eorHoldOff && $stable(pos_r))
    else $error("connected lamp lit while switching");
  AST_INHIBIT: assert property (
    connected && allInh && !keyEorReset |=> $stable(eorLamp_r))
    else $error("alarm raised on inhibited position");

endmodule // amp_scan_sequencer
`default_nettype wire

// ---- testbench/amp_bay_model.sv ----
// Behavioural bays, detectors and measuring set facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module amp_bay_model (
  // Scanner side
  input wire amp_scan_pkg::pos_t connectedPos,
  input wire logic amplifierConnectedLamp,
  // Test control
  input wire amp_scan_pkg::pos_t faultPos,
  input wire logic faultOn,
  input wire logic signed [7:0] devSet,
  // Detector outputs
  output logic groupEorDetect,
  output logic supergroupEorDetect,
  output logic signed [7:0] gainDeviation
);
  import amp_scan_pkg::*;
  // -----------------------------------------------------------
  // Sensing
  // -----------------------------------------------------------
  logic hit;
  assign hit = faultOn && (connectedPos == faultPos);
  // Open thermistor input between positions reads as end of range
  assign groupEorDetect = !amplifierConnectedLamp || hit;
  assign supergroupEorDetect = !amplifierConnectedLamp;
  // Open leads swing the meter hard over
  assign gainDeviation = amplifierConnectedLamp ? devSet : 8'h7F;
endmodule // amp_bay_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the amplifier scan sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import amp_scan_pkg::*;
  // -----------------------------------------------------------
  // Signals
  // -----------------------------------------------------------
  // Short counts keep a full scan cycle to a few thousand clocks
  localparam int TK = 4;
  localparam int D0 = 3;
  localparam int D1 = 5;
  localparam int TO = 20;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, slvErr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [SHELF_TOTAL-1:0] fastOpt, grpByp, sgByp, shelfEorLamp;
  logic gEor, sgEor, lamp, holdOff, gMeas, officeAlarm, faultOn;
  logic signed [7:0] dev, devSet;
  pos_t pos, faultPos, p, e;
  logic [3:0] baySel, bayAlarm;
  int err_count, comparisons, n, a, b, h;

  amp_scan_sequencer #(.NUM_BAYS(3), .TICK_CYCLES(TK), .DWELL_MS(D0),
    .DWELL1_MS(D1), .TIMEOUT_MS(TO)) dut (.clk(clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fastScanOption(fastOpt), .groupBypassOption(grpByp),
    .supergroupBypassOption(sgByp), .groupEorDetect(gEor),
    .supergroupEorDetect(sgEor), .gainDeviation(dev),
    .connectedPos(pos), .amplifierConnectedLamp(lamp),
    .groupMeasureOutput(gMeas), .bayConcentratorSel(baySel),
    .eorHoldOff(holdOff), .shelfEorLamp(shelfEorLamp),
    .bayAlarm(bayAlarm), .officeAlarm(officeAlarm));
  amp_bay_model bays (.connectedPos(pos), .amplifierConnectedLamp(lamp),
    .faultPos(faultPos), .faultOn(faultOn), .devSet(devSet),
    .groupEorDetect(gEor), .supergroupEorDetect(sgEor),
    .gainDeviation(dev));

  // -----------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------
  task automatic chk(input logic [51:0] g, input logic [51:0] x);
    comparisons++;
    if (g !== x)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic chkIn(input int g, input int lo, input int hi);
    chk(g >= lo && g <= hi, 1'b1);
  endtask

  task automatic apb(input logic w, input logic [7:0] ad,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic key(input int k);
    apb(1'b1, REG_CMD, 32'h0000_0001 << k);
    #1;
  endtask

  task automatic mode(input mode_t m);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(rd[11:9], m);
  endtask

  task automatic nextPos();
    p = pos;
    n = 0;
    while (pos === p && n < 80)
    begin
      @(posedge clk);
      n++;
    end
    chk(n < 80, 1'b1);
  endtask

  task automatic lenOf(input bit useLamp, output int len);
    len = 0;
    while ((useLamp ? lamp : holdOff) !== 1'b1) @(posedge clk);
    while ((useLamp ? lamp : holdOff) === 1'b1)
    begin
      if (!useLamp) chk(lamp, 1'b0);
      len++;
      @(posedge clk);
    end
  endtask

  function automatic pos_t succ(input pos_t q);
    pos_t s;
    s = q;
    s.grp = (q.grp == LAST_GRP) ? FIRST_GRP : q.grp + 3'h1;
    if (q.grp == LAST_GRP)
      s.shelf = (q.shelf == SGS_SHELF) ? FIRST_SHELF : q.shelf + 4'h1;
    if (q.grp == LAST_GRP && q.shelf == SGS_SHELF)
      s.bay = (q.bay == 2'h2) ? FIRST_BAY : q.bay + 2'h1;
    succ = s;
  endfunction

  // -----------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------
  task automatic t_reset_dwell();
    apb(1'b0, REG_LIMIT, 32'h0000_0000);
    chk(rd, {16'h0000, LIMIT_RST});
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(slvErr, 1'b1);
    mode(MODE_SCAN);
    lenOf(1'b1, a);
    lenOf(1'b0, h);
    chk(h, HOLDOFF_CYCLES);
    chk(pos, 9'h001);
    @(posedge clk);
    chk(baySel, 4'h1);
    chk(gMeas, 1'b1);
    lenOf(1'b1, b);
    chkIn(a, (D1 - 1) * TK, D1 * TK + 1);
    chkIn(b, (D0 - 1) * TK, D0 * TK + 1);
    $display("reset and dwell test done");
  endtask

  task automatic t_walk();
    for (int i = 0; i < 195; i++)
    begin
      e = succ(pos);
      nextPos();
      chk(pos, e);
    end
    chk(shelfEorLamp, 52'h0);
    $display("scan order test done");
  endtask

  task automatic t_hold_dev();
    apb(1'b1, REG_OPTION, 32'h0000_0002);
    key(CMD_HOLD);
    p = pos;
    repeat (40) @(posedge clk);
    chk(pos, p);
    chk(lamp, 1'b1);
    mode(MODE_HOLD);
    key(CMD_STEP);
    chk(pos, succ(p));
    apb(1'b1, REG_OPTION, 32'h0000_0000);
    key(CMD_STEP);
    chk(pos, succ(p));
    while (lamp !== 1'b1) @(posedge clk);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      devSet <= (i == 0) ? 8'h10 : (i == 1) ? 8'h11 : (i == 2) ? 8'hF0 : 8'hEF;
      repeat (3) @(posedge clk);
      chk(bayAlarm, {3'h0, i[0]} << pos.bay);
      chk(officeAlarm, i[0]);
    end
    devSet <= 8'h00;
    $display("hold and deviation test done");
  endtask

  task automatic t_select_eor();
    faultPos <= 9'h093;
    faultOn <= 1'b1;
    apb(1'b1, REG_SELECT, 32'h0000_0093);
    key(CMD_SELECT);
    chk(pos, 9'h093);
    mode(MODE_SELECT);
    while (lamp !== 1'b1) @(posedge clk);
    repeat (3) @(posedge clk);
    chk(shelfEorLamp, 52'h0_0000_0000_8000);
    faultOn <= 1'b0;
    key(CMD_SCAN);
    chk(pos, 9'h093);
    mode(MODE_SCAN);
    e = succ(pos);
    nextPos();
    chk(pos, e);
    chk(shelfEorLamp[15], 1'b1);
    key(CMD_EOR_RESET);
    repeat (2) @(posedge clk);
    chk(shelfEorLamp, 52'h0);
    $display("select and alarm latch test done");
  endtask

  task automatic t_timeout();
    key(CMD_HOLD);
    p = pos;
    repeat (TO * TK - 10) @(posedge clk);
    mode(MODE_HOLD);
    chk(pos, p);
    // Read just after the timer runs out, before the resumed dwell ends
    repeat (5) @(posedge clk);
    mode(MODE_SCAN);
    chk(pos, p);
    $display("mode timeout test done");
  endtask

  task automatic t_options();
    fastOpt <= '1;
    grpByp <= '1;
    faultPos <= 9'h180;
    faultOn <= 1'b1;
    apb(1'b1, REG_OPTION, 32'h0000_0001);
    apb(1'b1, REG_SELECT, 32'h0000_0164);
    key(CMD_SELECT);
    key(CMD_SCAN);
    e = 9'h180;
    for (int i = 0; i < 14; i++)
    begin
      nextPos();
      chk(pos, e);
      e = pos_t'((e == 9'h1D8) ? 9'h000 : e + 9'h008);
    end
    chk(shelfEorLamp, 52'h0);
    $display("spare bank and bypass test done");
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // -----------------------------------------------------------
  // Run
  // -----------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    #200000;
    err_count++;
    print_verdict();
  end

  initial
  begin
    {rstn, psel, penable, pwrite, faultOn} = 5'h00;
    {paddr, pwdata, devSet, faultPos} = 0;
    {fastOpt, grpByp, sgByp} = 0;
    err_count = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_reset_dwell();
    t_walk();
    t_hold_dev();
    t_select_eor();
    t_timeout();
    t_options();
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
